// File: core/cfg_word_decoder.sv
// Purpose: latch and decode the configuration words for dependent units
// Assumes: dependent units stay in reset until loaded_o is high
// Notes:   words are read-only over apb; values hold until next reset
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module cfg_word_decoder
(
    // clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    input  wire logic                              por_i,
    // program port
    input  wire logic                              prog_we_i,
    input  wire logic [cfg_decode_pkg::IDX_W-1:0]  prog_idx_i,
    input  wire logic [cfg_decode_pkg::WORD_W-1:0] prog_data_i,
    // apb slave
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [cfg_decode_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // decoded configuration
    output logic                                   loaded_o,
    output logic                                   selftest_run_o,
    output logic                                   boot_swap_inhibit_o,
    output logic                                   scan_port_enable_o,
    output logic                                   debug_pair1_sel_o,
    output logic                                   debug_pair2_sel_o,
    output logic                                   debug_pair3_sel_o,
    output logic [31:0]                            deadman_window_interval_o,
    output logic [31:0]                            deadman_count_limit_o,
    output logic                                   deadman_disable_o
);
    // width of the apb data bus
    localparam int DATA_W  = 32;
    // zero padding above a word on the bus
    localparam int PAD_W   = DATA_W - cfg_decode_pkg::WORD_W;
    // top bit of the word index inside paddr
    localparam int IDX_MSB = cfg_decode_pkg::ADDR_LSB + cfg_decode_pkg::IDX_W - 1;
    // width of the debug channel code
    localparam int CHAN_W  = $bits(cfg_decode_pkg::CHAN_RESERVED);
    // last word the loader fetches
    localparam logic [cfg_decode_pkg::IDX_W-1:0] LAST_IDX = cfg_decode_pkg::IDX_DEADMAN;

    // fetch port toward the word store
    nvm_port_if nvm ();

    // loader state and fetch pointer
    cfg_decode_pkg::load_state_t       state_r;        // current loader state
    cfg_decode_pkg::load_state_t       state_nxt;      // next loader state
    logic [cfg_decode_pkg::IDX_W-1:0]  fetch_idx_r;    // word being read from the store
    logic [cfg_decode_pkg::IDX_W-1:0]  fetch_idx_nxt;  // next word to read
    // capture pipeline, one cycle behind the fetch pointer
    logic                              cap_valid_r;    // store data is a fetched word
    logic [cfg_decode_pkg::IDX_W-1:0]  cap_idx_r;      // which word the store data is
    logic                              loaded_r;       // all words latched
    logic                              por_flag_r;     // last reset was power-on

    // latched words, unimplemented bits forced to one
    logic [cfg_decode_pkg::WORD_W-1:0] power_word_r;   // power-on word
    logic [cfg_decode_pkg::WORD_W-1:0] debug_word_r;   // debug word
    logic [cfg_decode_pkg::WORD_W-1:0] win_low_r;      // window interval, low half
    logic [cfg_decode_pkg::WORD_W-1:0] win_high_r;     // window interval, high half
    logic [cfg_decode_pkg::WORD_W-1:0] cnt_low_r;      // count limit, low half
    logic [cfg_decode_pkg::WORD_W-1:0] cnt_high_r;     // count limit, high half
    logic [cfg_decode_pkg::WORD_W-1:0] deadman_word_r; // deadman disable word

    // decoded flags that need more than one bit
    logic                              selftest_run_r; // self-test requested this reset
    logic                              pair1_r;        // debug on clock/data pair 1
    logic                              pair2_r;        // debug on clock/data pair 2
    logic                              pair3_r;        // debug on clock/data pair 3
    logic                              badchan_r;      // reserved channel code seen
    logic [CHAN_W-1:0]                 chan_code;      // channel code in store data

    // apb side
    logic [cfg_decode_pkg::IDX_W-1:0]  bus_idx;        // word addressed by paddr
    logic                              addr_hit;       // paddr inside the word map
    logic                              setup_phase;    // first cycle of a transfer
    logic                              access_phase;   // second cycle of a transfer
    logic [DATA_W-1:0]                 status_word;    // loader status as read back
    logic [DATA_W-1:0]                 rd_mux;         // word selected for reading
    logic [DATA_W-1:0]                 prdata_r;       // registered read data

    // program-once word store; rst_i leaves its contents alone
    cfg_word_store u_store
    (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .prog_we_i   (prog_we_i),
        .prog_idx_i  (prog_idx_i),
        .prog_data_i (prog_data_i),
        .rd          (nvm.store)
    );

    // the store always reads the word the loader points at
    assign nvm.idx = fetch_idx_r;

    // loader next state: one fetch per word, then rest until reset
    always_comb
    begin
        state_nxt     = state_r;
        fetch_idx_nxt = fetch_idx_r;
        case (state_r)
            cfg_decode_pkg::LD_IDLE:
            begin
                state_nxt     = cfg_decode_pkg::LD_FETCH;
                fetch_idx_nxt = cfg_decode_pkg::IDX_POWER_ON;
            end
            cfg_decode_pkg::LD_FETCH:
            begin
                if (fetch_idx_r == LAST_IDX)
                begin
                    state_nxt = cfg_decode_pkg::LD_DONE;          // last data lands next cycle
                end
                else
                begin
                    fetch_idx_nxt = fetch_idx_r + 1'b1;           // step to the following word
                end
            end
            cfg_decode_pkg::LD_DONE: state_nxt = cfg_decode_pkg::LD_DONE;    // frozen until reset
            default:                 state_nxt = cfg_decode_pkg::LD_IDLE;    // unknown: restart
        endcase
    end

    // loader state register; reset holds it idle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= cfg_decode_pkg::LD_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // fetch pointer register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fetch_idx_r <= cfg_decode_pkg::IDX_POWER_ON;
        end
        else
        begin
            fetch_idx_r <= fetch_idx_nxt;
        end
    end

    // capture pipeline follows the one-cycle store read
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cap_valid_r <= 1'b0;
            cap_idx_r   <= cfg_decode_pkg::IDX_POWER_ON;
        end
        else
        begin
            cap_valid_r <= (state_r == cfg_decode_pkg::LD_FETCH);
            cap_idx_r   <= fetch_idx_r;
        end
    end

    // loaded rises with the last captured word and falls only in reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            loaded_r <= 1'b0;
        end
        else if (cap_valid_r && cap_idx_r == LAST_IDX)
        begin
            loaded_r <= 1'b1;
        end
    end

    // remember whether the reset that is running came from power-on
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            por_flag_r <= por_i;
        end
    end

    // word latch: each word taken once per reset, unimplemented bits read one
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            power_word_r   <= cfg_decode_pkg::ERASED_WORD;
            debug_word_r   <= cfg_decode_pkg::ERASED_WORD;
            win_low_r      <= cfg_decode_pkg::ERASED_WORD;
            win_high_r     <= cfg_decode_pkg::ERASED_WORD;
            cnt_low_r      <= cfg_decode_pkg::ERASED_WORD;
            cnt_high_r     <= cfg_decode_pkg::ERASED_WORD;
            deadman_word_r <= cfg_decode_pkg::ERASED_WORD;
        end
        else if (cap_valid_r)
        begin
            case (cap_idx_r)
                cfg_decode_pkg::IDX_POWER_ON: power_word_r   <= nvm.data | ~cfg_decode_pkg::MASK_POWER_ON;
                cfg_decode_pkg::IDX_DEBUG:    debug_word_r   <= nvm.data | ~cfg_decode_pkg::MASK_DEBUG;
                cfg_decode_pkg::IDX_WIN_LOW:  win_low_r      <= nvm.data | ~cfg_decode_pkg::MASK_HALF;
                cfg_decode_pkg::IDX_WIN_HIGH: win_high_r     <= nvm.data | ~cfg_decode_pkg::MASK_HALF;
                cfg_decode_pkg::IDX_CNT_LOW:  cnt_low_r      <= nvm.data | ~cfg_decode_pkg::MASK_HALF;
                cfg_decode_pkg::IDX_CNT_HIGH: cnt_high_r     <= nvm.data | ~cfg_decode_pkg::MASK_HALF;
                cfg_decode_pkg::IDX_DEADMAN:  deadman_word_r <= nvm.data | ~cfg_decode_pkg::MASK_DEADMAN;
                default:                      power_word_r   <= power_word_r;
            endcase
        end
    end

    // self-test runs only after a power-on reset with the skip bit clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            selftest_run_r <= 1'b0;
        end
        else if (cap_valid_r && cap_idx_r == cfg_decode_pkg::IDX_POWER_ON)
        begin
            // warm resets never start it, whatever the bit says
            selftest_run_r <= por_flag_r && !nvm.data[cfg_decode_pkg::SELFTEST_SKIP_BIT];
        end
    end

    // channel code field of the word arriving from the store
    assign chan_code = nvm.data[cfg_decode_pkg::CHAN_LSB +: CHAN_W];

    // debug channel routing from the two-bit code
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // erased code selects pair 1
            pair1_r   <= 1'b1;
            pair2_r   <= 1'b0;
            pair3_r   <= 1'b0;
            badchan_r <= 1'b0;
        end
        else if (cap_valid_r && cap_idx_r == cfg_decode_pkg::IDX_DEBUG)
        begin
            case (chan_code)
                cfg_decode_pkg::CHAN_PAIR1:
                begin
                    pair1_r   <= 1'b1;
                    pair2_r   <= 1'b0;
                    pair3_r   <= 1'b0;
                    badchan_r <= 1'b0;
                end
                cfg_decode_pkg::CHAN_PAIR2:
                begin
                    pair1_r   <= 1'b0;
                    pair2_r   <= 1'b1;
                    pair3_r   <= 1'b0;
                    badchan_r <= 1'b0;
                end
                cfg_decode_pkg::CHAN_PAIR3:
                begin
                    pair1_r   <= 1'b0;
                    pair2_r   <= 1'b0;
                    pair3_r   <= 1'b1;
                    badchan_r <= 1'b0;
                end
                default:
                begin
                    // reserved code: no pair routed, flagged in status
                    pair1_r   <= 1'b0;
                    pair2_r   <= 1'b0;
                    pair3_r   <= 1'b0;
                    badchan_r <= 1'b1;
                end
            endcase
        end
    end

    // apb address decode: word index above the byte lanes
    assign bus_idx      = paddr[IDX_MSB:cfg_decode_pkg::ADDR_LSB];
    assign addr_hit     = (paddr[cfg_decode_pkg::ADDR_W-1:IDX_MSB+1] == '0);
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;

    // loader status, read back at the status index
    always_comb
    begin
        status_word                                  = '0;
        status_word[cfg_decode_pkg::ST_LOADED_BIT]   = loaded_r;
        status_word[cfg_decode_pkg::ST_BADCHAN_BIT]  = badchan_r;
        status_word[cfg_decode_pkg::ST_POR_BIT]      = por_flag_r;
        status_word[cfg_decode_pkg::ST_SELFTEST_BIT] = selftest_run_r;
    end

    // read multiplexer; words sit in the low bits, zero above
    always_comb
    begin
        rd_mux = '0;
        if (addr_hit)
        begin
            case (bus_idx)
                cfg_decode_pkg::IDX_POWER_ON: rd_mux = {{PAD_W{1'b0}}, power_word_r};
                cfg_decode_pkg::IDX_DEBUG:    rd_mux = {{PAD_W{1'b0}}, debug_word_r};
                cfg_decode_pkg::IDX_WIN_LOW:  rd_mux = {{PAD_W{1'b0}}, win_low_r};
                cfg_decode_pkg::IDX_WIN_HIGH: rd_mux = {{PAD_W{1'b0}}, win_high_r};
                cfg_decode_pkg::IDX_CNT_LOW:  rd_mux = {{PAD_W{1'b0}}, cnt_low_r};
                cfg_decode_pkg::IDX_CNT_HIGH: rd_mux = {{PAD_W{1'b0}}, cnt_high_r};
                cfg_decode_pkg::IDX_DEADMAN:  rd_mux = {{PAD_W{1'b0}}, deadman_word_r};
                default:                      rd_mux = status_word;
            endcase
        end
    end

    // read data registered in the setup cycle, stable through access
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prdata_r <= '0;
        end
        else if (setup_phase && !pwrite)
        begin
            prdata_r <= rd_mux;
        end
    end

    // no wait states; writes and addresses off the map are refused
    assign pready  = access_phase;
    assign pslverr = access_phase && (pwrite || !addr_hit);

    // decoded outputs straight from the latched registers
    assign prdata                    = prdata_r;
    assign loaded_o                  = loaded_r;
    assign selftest_run_o            = selftest_run_r;
    assign boot_swap_inhibit_o       = debug_word_r[cfg_decode_pkg::BOOT_INHIBIT_BIT];
    assign scan_port_enable_o        = debug_word_r[cfg_decode_pkg::SCAN_ENABLE_BIT];
    assign debug_pair1_sel_o         = pair1_r;
    assign debug_pair2_sel_o         = pair2_r;
    assign debug_pair3_sel_o         = pair3_r;
    assign deadman_window_interval_o = {win_high_r[cfg_decode_pkg::HALF_W-1:0],
                                        win_low_r[cfg_decode_pkg::HALF_W-1:0]};
    assign deadman_count_limit_o     = {cnt_high_r[cfg_decode_pkg::HALF_W-1:0],
                                        cnt_low_r[cfg_decode_pkg::HALF_W-1:0]};
    assign deadman_disable_o         = deadman_word_r[cfg_decode_pkg::DEADMAN_DIS_BIT];
endmodule : cfg_word_decoder

// File: shared/cfg_decode_pkg.sv
// Purpose: constants for the configuration word decoder
// Assumes: 24-bit program-once words, 32-bit apb data
// Notes:   word index times four gives the byte address
package cfg_decode_pkg;
    localparam int WORD_W        = 24;                // configuration word width
    localparam int NUM_WORDS     = 7;                 // words held by the decoder
    localparam int IDX_W         = 3;                 // word index width
    // word indices, also apb word addresses
    localparam logic [IDX_W-1:0] IDX_POWER_ON   = 3'h0;
    localparam logic [IDX_W-1:0] IDX_DEBUG      = 3'h1;
    localparam logic [IDX_W-1:0] IDX_WIN_LOW    = 3'h2;
    localparam logic [IDX_W-1:0] IDX_WIN_HIGH   = 3'h3;
    localparam logic [IDX_W-1:0] IDX_CNT_LOW    = 3'h4;
    localparam logic [IDX_W-1:0] IDX_CNT_HIGH   = 3'h5;
    localparam logic [IDX_W-1:0] IDX_DEADMAN    = 3'h6;
    localparam logic [IDX_W-1:0] IDX_STATUS     = 3'h7;
    // apb address decode
    localparam int ADDR_W        = 12;
    localparam int ADDR_LSB      = 2;
    // field positions
    localparam int SELFTEST_SKIP_BIT = 6;
    localparam int BOOT_INHIBIT_BIT  = 15;
    localparam int SCAN_ENABLE_BIT   = 5;
    localparam int CHAN_LSB          = 0;
    localparam int DEADMAN_DIS_BIT   = 0;
    localparam int HALF_W            = 16;
    // implemented-bit masks; everything else reads as one
    localparam logic [WORD_W-1:0] MASK_POWER_ON = 24'h00_0070;
    localparam logic [WORD_W-1:0] MASK_DEBUG    = 24'h00_80A3;
    localparam logic [WORD_W-1:0] MASK_HALF     = 24'h00_FFFF;
    localparam logic [WORD_W-1:0] MASK_DEADMAN  = 24'h00_0001;
    localparam logic [WORD_W-1:0] ERASED_WORD   = 24'hFF_FFFF;
    // debug channel codes
    localparam logic [1:0] CHAN_PAIR1    = 2'h3;
    localparam logic [1:0] CHAN_PAIR2    = 2'h2;
    localparam logic [1:0] CHAN_PAIR3    = 2'h1;
    localparam logic [1:0] CHAN_RESERVED = 2'h0;
    // status register bits
    localparam int ST_LOADED_BIT  = 0;
    localparam int ST_BADCHAN_BIT = 1;
    localparam int ST_POR_BIT     = 2;
    localparam int ST_SELFTEST_BIT= 3;
    // loader states
    typedef enum logic [1:0] {LD_IDLE, LD_FETCH, LD_DONE} load_state_t;
endpackage : cfg_decode_pkg

// File: shared/nvm_port_if.sv
// Purpose: fetch port between loader and word store
// Assumes: one-cycle registered read
// Notes:   carries index and data
`timescale 1ns/1ps
interface nvm_port_if;
    logic [cfg_decode_pkg::IDX_W-1:0]  idx;   // word index
    logic [cfg_decode_pkg::WORD_W-1:0] data;  // registered read data
    modport loader (output idx, input data);
    modport store  (input idx, output data);
endinterface : nvm_port_if

// File: core/cfg_word_store.sv
// Purpose: program-once word store for configuration words
// Assumes: programmer writes each word through the program port
// Notes:   erased words read all ones; a word accepts one program only
`timescale 1ns/1ps
module cfg_word_store
(
    // clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    // program port from the external programmer
    input  wire logic                              prog_we_i,
    input  wire logic [cfg_decode_pkg::IDX_W-1:0]  prog_idx_i,
    input  wire logic [cfg_decode_pkg::WORD_W-1:0] prog_data_i,
    // read port
    nvm_port_if.store                              rd
);
    logic [cfg_decode_pkg::WORD_W-1:0] mem_r [cfg_decode_pkg::NUM_WORDS]; // word array, valid where used
    logic [cfg_decode_pkg::NUM_WORDS-1:0] used_r = '0;                    // programmed flags, clear when erased
    // program once: later writes ignored, nonvolatile so rst_i leaves it
    always_ff @(posedge clk_i)
    begin
        if (prog_we_i && int'(prog_idx_i) < cfg_decode_pkg::NUM_WORDS
            && !used_r[prog_idx_i])
        begin
            mem_r[prog_idx_i]  <= prog_data_i;
            used_r[prog_idx_i] <= 1'b1;
        end
    end
    // registered read; a word never programmed reads as erased
    always_ff @(posedge clk_i)
    begin
        if (int'(rd.idx) < cfg_decode_pkg::NUM_WORDS && used_r[rd.idx])
        begin
            rd.data <= mem_r[rd.idx];
        end
        else
        begin
            rd.data <= cfg_decode_pkg::ERASED_WORD;
        end
    end
endmodule : cfg_word_store

// File: sim/cfg_word_decoder_props.sv
// Purpose: port-level checks for the configuration decoder
// Assumes: apb read-only words, decode after reset release
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module cfg_word_decoder_props
(
    input wire logic        clk_i, rst_i, psel, penable, pwrite, pready, loaded_o,
    input wire logic        debug_pair1_sel_o, debug_pair2_sel_o, debug_pair3_sel_o,
    input wire logic        boot_swap_inhibit_o, scan_port_enable_o, deadman_disable_o,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata, deadman_window_interval_o, deadman_count_limit_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    sequence s_held; loaded_o && $past(loaded_o); endsequence
    a_apb_answer: assert property (s_setup |=> s_access ##[0:15] pready) else $error("apb no answer");
    a_upper_ones: assert property (psel && penable && pready && !pwrite && paddr < 12'h01C |-> prdata[23:16] == 8'hFF)
        else $error("upper byte not ones");
    a_pair_onehot: assert property (loaded_o |-> $onehot({debug_pair1_sel_o, debug_pair2_sel_o, debug_pair3_sel_o}))
        else $error("pair select not one-hot");
    a_window_frozen: assert property (s_held |-> $stable(deadman_window_interval_o)) else $error("window moved");
    a_count_frozen: assert property (s_held |-> $stable(deadman_count_limit_o)) else $error("count moved");
    a_flags_frozen: assert property (s_held |-> $stable({boot_swap_inhibit_o, scan_port_enable_o, deadman_disable_o}))
        else $error("flags moved");
    a_load_bound: assert property ($fell(rst_i) |-> ##[0:63] loaded_o) else $error("load too slow");
    a_reset_clears: assert property (disable iff (1'b0) rst_i |=> !loaded_o) else $error("loaded in reset");
endmodule : cfg_word_decoder_props

// File: sim/config_word_decode_deadman_debug_tb.sv
// Purpose: program, latch and read back the configuration words
// Assumes: loading starts once reset is released
// Notes:   expected words follow the implemented-bit layout
`timescale 1ns/1ps
module config_word_decode_deadman_debug_tb;
    logic clk_i = 0, rst_i = 1, por_i = 1, prog_we_i = 0, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, loaded_o, selftest_run_o, boot_swap_inhibit_o, scan_port_enable_o, deadman_disable_o;
    logic debug_pair1_sel_o, debug_pair2_sel_o, debug_pair3_sel_o;
    logic err;
    logic [2:0] prog_idx_i = 0;
    logic [23:0] prog_data_i = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, deadman_window_interval_o, deadman_count_limit_o;
    logic [23:0] pv[7] = '{24'h00_0430, 24'h00_0082,
                           24'h00_1234, 24'h00_5678, 24'h00_9ABC, 24'h00_DEF0, 24'h00_0000};
    logic [23:0] ev[7] = '{24'hFF_FFBF, 24'hFF_7FDE, 24'hFF_1234, 24'hFF_5678, 24'hFF_9ABC, 24'hFF_DEF0, 24'hFF_FFFE};
    int mismatches = 0, tests_run = 0, cyc = 0;
    always #2 clk_i = ~clk_i;
    cfg_word_decoder uut (.*);
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    always @(posedge clk_i) if (++cyc == 5000) begin mismatches++; finish_test(); end
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        tests_run++;
        if (s !== e) begin mismatches++; $display("mismatch %s exp %h got %h", n, e, s); end
    endtask : chk
    task automatic apb(logic w, logic [11:0] a);
        @(posedge clk_i); psel <= 1; pwrite <= w; paddr <= a; pwdata <= 32'h0000_0000;
        @(posedge clk_i); penable <= 1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rd = prdata; err = pslverr; psel <= 0; penable <= 0;
    endtask : apb
    task automatic prog(int i, logic [23:0] d);
        @(posedge clk_i); prog_we_i <= 1; prog_idx_i <= i[2:0]; prog_data_i <= d;
        @(posedge clk_i); prog_we_i <= 0;
    endtask : prog
    task automatic rst(logic p);
        @(posedge clk_i); rst_i <= 1; por_i <= p;
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        wait (loaded_o === 1'b1); @(posedge clk_i);
    endtask : rst
    function automatic logic [31:0] flags();
        return {25'h0, selftest_run_o, boot_swap_inhibit_o, scan_port_enable_o,
                debug_pair1_sel_o, debug_pair2_sel_o, debug_pair3_sel_o, deadman_disable_o};
    endfunction : flags
    initial begin
        rst(1);
        chk("erased flags", flags(), 32'h0000_0039);
        chk("erased window", deadman_window_interval_o, 32'hFFFF_FFFF);
        for (int i = 0; i < 7; i++) prog(i, pv[i]);
        prog(1, 24'hFF_FFFF);
        chk("frozen flags", flags(), 32'h0000_0039);
        rst(1);
        chk("por flags", flags(), 32'h0000_0044);
        chk("window", deadman_window_interval_o, 32'h5678_1234);
        chk("count", deadman_count_limit_o, 32'hDEF0_9ABC);
        for (int i = 0; i < 7; i++) begin apb(0, 12'(i * 4)); chk("word", rd[23:0], ev[i]); end
        apb(0, 12'h01C); chk("status", rd, 32'h0000_000D);
        apb(1, 12'h008); chk("write refused", {31'h0, err}, 32'h0000_0001);
        apb(0, 12'h008);
        chk("read only", rd[23:0], 24'hFF_1234);
        rst(0);
        chk("warm selftest", selftest_run_o, 1'b0);
        finish_test();
    end
endmodule : config_word_decode_deadman_debug_tb
bind cfg_word_decoder cfg_word_decoder_props u_props (.*);
